// File: core/bus_state_pkg.sv
/*
  Constants, encodings and timing figures shared by the bus-state and
  power-control block. Assumes a single 10 MHz clock domain.

*/
package bus_state_pkg;
  // Cycle type codes {mem_io, data_code, write_read, lock}
  localparam logic [3:0] CYC_INTA = 4'h0;
  localparam logic [3:0] CYC_IO_RD = 4'h5;
  localparam logic [3:0] CYC_IO_WR = 4'h7;
  localparam logic [3:0] CYC_CODE_RD = 4'h9;
  localparam logic [3:0] CYC_HALT = 4'hB;
  localparam logic [3:0] CYC_LK_RD = 4'hC;
  localparam logic [3:0] CYC_DATA_RD = 4'hD;
  localparam logic [3:0] CYC_LK_WR = 4'hE;
  localparam logic [3:0] CYC_DATA_WR = 4'hF;
  // Definition levels set by reset: mem_io 0, data_code 1, write_read 0, lock 1
  localparam logic [3:0] DEF_RESET = 4'h5;
  // Halt and shutdown word addresses
  localparam logic [22:0] ADDR_HALT = 23'h000002;
  localparam logic [22:0] ADDR_SHUTDOWN = 23'h000000;
  localparam logic [22:0] ADDR_ALL_ONES = 23'h7FFFFF;
  // Config register 0 field positions
  localparam int CONFIG_CTRL_REG0_SUSPEND_REQ_N_BIT = 0;
  localparam int CONFIG_CTRL_REG0_CKD_BIT = 6;
  localparam logic [7:0] CONFIG_CTRL_REG0_RESET = 8'h00;
  // PLL lock time in ns and clock period in ns
  localparam int PLL_LOCK_NS = 20000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: core/bus_state_ctrl.sv
/*
  Bus-state, cycle-definition and power-control logic.
  Assumes pins arrive asynchronously and are synchronised here; the core
  side (cycle requests, drain and config writes) is on I_CLK.
*/
`timescale 1ns/10ps
module bus_state_ctrl #(
  parameter int LOCK_CYC = bus_state_pkg::PLL_LOCK_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Pins from the system
  input wire logic I_HOLD_REQ,
  input wire logic I_SUSPEND_REQ_N,
  input wire logic I_FLOAT_ALL_N,
  input wire logic I_CACHE_INV_N,
  input wire logic I_COPROC_BUSY_N,
  input wire logic I_NMI,
  input wire logic I_MASKABLE_IRQ,
  input wire logic I_CLK_FREQ_CHANGE,
  // Core side
  input wire logic i_cyc_start,
  input wire logic [3:0] i_cyc_type,
  input wire logic [22:0] i_cyc_addr,
  input wire logic i_cyc_pipelined,
  input wire logic i_shutdown,
  input wire logic i_core_drained,
  input wire logic i_irq_unmasked,
  input wire logic i_halt_exec,
  input wire logic i_config_ctrl_reg0_wr,
  input wire logic [7:0] i_config_ctrl_reg0_wdata,
  // Pins to the system
  output logic [22:0] O_WORD_ADDRESS,
  output logic O_ADDR_OE,
  output logic O_ADDR_STROBE_N,
  output logic O_MEM_IO,
  output logic O_DATA_CODE,
  output logic O_WRITE_READ,
  output logic O_LOCK_N,
  output logic O_DEF_OE,
  output logic O_HIGH_BYTE_EN_N,
  output logic O_LOW_BYTE_EN_N,
  output logic O_DATA_BUS_OE,
  output logic O_SMM_STROBE_OE,
  output logic O_HOLD_ACK_OUT,
  output logic O_SUSPEND_ACK_N,
  output logic O_SUSPEND_ACK_OE,
  // Core side status
  output logic o_core_clk_en,
  output logic o_doubled,
  output logic o_self_test_req,
  output logic o_wake_nmi,
  output logic o_wake_irq,
  output logic [7:0] o_config_ctrl_reg0
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  ////////////////////////////////////////////////////////////////////////

  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pin_raw; // Pin levels, active-low pins inverted
  logic [NSYNC-1:0] sync1_r; // First stage, read only by stage two
  logic [NSYNC-1:0] sync2_r; // Synchronised levels

  assign pin_raw = {I_HOLD_REQ, ~I_SUSPEND_REQ_N, ~I_FLOAT_ALL_N, ~I_CACHE_INV_N,
                    ~I_COPROC_BUSY_N, I_NMI, I_MASKABLE_IRQ, I_CLK_FREQ_CHANGE};

  // Two flops per pin; left without reset so that the busy level held
  // through reset has reached stage two by the first edge after release
  always_ff @(posedge I_CLK) begin
    sync1_r <= pin_raw;
    sync2_r <= sync1_r;
  end

  wire hold_s = sync2_r[7];     // Hold request
  wire suspend_req_n_s = sync2_r[6];     // Suspend request active
  wire float_s = sync2_r[5];    // Float all
  wire busy_s = sync2_r[3];     // Coprocessor busy
  wire nmi_s = sync2_r[2];      // Nonmaskable interrupt
  wire irq_s = sync2_r[1];      // Maskable interrupt
  wire fchg_s = sync2_r[0];     // Input clock frequency changed

  ////////////////////////////////////////////////////////////////////////
  // Config register 0
  ////////////////////////////////////////////////////////////////////////

  logic [7:0] config_ctrl_reg0_r; // Config register 0
  wire suspend_req_n_en = config_ctrl_reg0_r[bus_state_pkg::CONFIG_CTRL_REG0_SUSPEND_REQ_N_BIT];
  wire ckd_bit = config_ctrl_reg0_r[bus_state_pkg::CONFIG_CTRL_REG0_CKD_BIT];

  // Written when the final write leaves the pipeline
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      config_ctrl_reg0_r <= bus_state_pkg::CONFIG_CTRL_REG0_RESET;
    end else if (i_config_ctrl_reg0_wr) begin
      config_ctrl_reg0_r <= i_config_ctrl_reg0_wdata;
    end
  end
  assign o_config_ctrl_reg0 = config_ctrl_reg0_r;

  ////////////////////////////////////////////////////////////////////////
  // PLL lock timer and doubling mode
  ////////////////////////////////////////////////////////////////////////

  logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_r; // Cycles since doubling asked
  logic doubled_r; // Running doubled
  wire lock_done = (lock_cnt_r == ($clog2(LOCK_CYC+1))'(LOCK_CYC));

  // Counter restarts on clear or on any input frequency change
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lock_cnt_r <= '0;
      doubled_r <= 1'b0;
    end else if (!ckd_bit || fchg_s) begin
      lock_cnt_r <= '0;
      doubled_r <= 1'b0;
    end else if (lock_done) begin
      doubled_r <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end
  assign o_doubled = doubled_r;

  ////////////////////////////////////////////////////////////////////////
  // Power state machine
  ////////////////////////////////////////////////////////////////////////

  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_DRAIN = 5'b00010,
    ST_SUSPEND_REQ_N = 5'b00100,
    ST_HALT_SUSPEND_REQ_N = 5'b01000,
    ST_HOLD = 5'b10000
  } pwr_e;
  pwr_e st_r;
  pwr_e st_nxt;

  wire suspend_req_n_req = suspend_req_n_s && suspend_req_n_en;
  wire wake_nmi = (st_r == ST_HALT_SUSPEND_REQ_N) && nmi_s;
  wire wake_irq = (st_r == ST_HALT_SUSPEND_REQ_N) && irq_s && i_irq_unmasked;

  // Next state: hold has priority, then suspend flow
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_RUN: begin
        if (hold_s) begin
          st_nxt = ST_HOLD;
        end else if (suspend_req_n_req) begin
          st_nxt = ST_DRAIN;
        end else if (i_halt_exec) begin
          st_nxt = ST_HALT_SUSPEND_REQ_N;
        end
      end
      ST_DRAIN: begin
        if (i_core_drained && !busy_s) begin
          st_nxt = ST_SUSPEND_REQ_N;
        end
      end
      ST_SUSPEND_REQ_N: begin
        if (!suspend_req_n_req) begin
          st_nxt = ST_RUN;
        end
      end
      ST_HALT_SUSPEND_REQ_N: begin
        if (wake_nmi || wake_irq) begin
          st_nxt = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!hold_s) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_r <= ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  wire in_hold = (st_r == ST_HOLD);
  wire in_suspend_req_n = (st_r == ST_SUSPEND_REQ_N) || (st_r == ST_HALT_SUSPEND_REQ_N);
  wire bus_float = in_hold || float_s;
  assign o_core_clk_en = !in_suspend_req_n && !in_hold;
  assign o_wake_nmi = wake_nmi;
  assign o_wake_irq = wake_irq;

  ////////////////////////////////////////////////////////////////////////
  // Reset release and self-test request
  ////////////////////////////////////////////////////////////////////////

  logic rst_seen_r; // First clock after reset release
  logic self_test_r; // Busy low at the first edge after release

  // Busy sampled at the first edge after release
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_seen_r <= 1'b0;
      self_test_r <= 1'b0;
    end else if (!rst_seen_r) begin
      rst_seen_r <= 1'b1;
      self_test_r <= busy_s;
    end
  end
  assign o_self_test_req = self_test_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle definition outputs
  ////////////////////////////////////////////////////////////////////////

  logic [3:0] def_r; // {mem_io, data_code, write_read, lock}
  logic lock_pend_r; // Lock waiting for pipelined cycle start
  logic [22:0] addr_r; // Word address
  logic be_hi_r; // High byte enable
  logic be_lo_r; // Low byte enable
  logic ads_r; // Address strobe active
  wire is_halt = (i_cyc_type == bus_state_pkg::CYC_HALT);
  wire cyc_go = i_cyc_start && (st_r == ST_RUN);

  // Definition latched with strobe; lock deferred when pipelined
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      def_r <= bus_state_pkg::DEF_RESET;
      lock_pend_r <= 1'b0;
      addr_r <= bus_state_pkg::ADDR_ALL_ONES;
      be_hi_r <= 1'b1;
      be_lo_r <= 1'b1;
      ads_r <= 1'b0;
    end else begin
      ads_r <= cyc_go;
      lock_pend_r <= 1'b0;
      if (lock_pend_r) begin
        def_r[0] <= 1'b0;
      end
      if (cyc_go) begin
        def_r[3:1] <= i_cyc_type[3:1];
        def_r[0] <= i_cyc_pipelined ? 1'b1 : i_cyc_type[0];
        lock_pend_r <= i_cyc_pipelined && !i_cyc_type[0];
        if (is_halt) begin
          addr_r <= i_shutdown ? bus_state_pkg::ADDR_SHUTDOWN
                               : bus_state_pkg::ADDR_HALT;
          be_hi_r <= 1'b0;
          be_lo_r <= 1'b1;
        end else begin
          addr_r <= i_cyc_addr;
          be_hi_r <= 1'b1;
          be_lo_r <= 1'b1;
        end
      end
    end
  end

  // Pin drive: reset forces fixed levels, hold floats all but acks
  wire rst_act = !rst_seen_r;
  assign O_WORD_ADDRESS = rst_act ? bus_state_pkg::ADDR_ALL_ONES : addr_r;
  assign O_ADDR_STROBE_N = rst_act ? 1'b1 : !ads_r;
  assign O_MEM_IO = rst_act ? 1'b0 : def_r[3];
  assign O_DATA_CODE = rst_act ? 1'b1 : def_r[2];
  assign O_WRITE_READ = rst_act ? 1'b0 : def_r[1];
  assign O_LOCK_N = rst_act ? 1'b1 : def_r[0];
  assign O_HIGH_BYTE_EN_N = rst_act ? 1'b0 : !be_hi_r;
  assign O_LOW_BYTE_EN_N = rst_act ? 1'b0 : !be_lo_r;
  assign O_ADDR_OE = !bus_float;
  assign O_DEF_OE = !bus_float;
  assign O_DATA_BUS_OE = 1'b0;
  assign O_SMM_STROBE_OE = 1'b0;
  assign O_HOLD_ACK_OUT = in_hold;
  assign O_SUSPEND_ACK_N = !in_suspend_req_n;
  assign O_SUSPEND_ACK_OE = suspend_req_n_en;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////

  sequence drain_done_s;
    (st_r == ST_DRAIN) && i_core_drained && !busy_s;
  endsequence

  hold_float_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    in_hold |-> !O_ADDR_OE && !O_DEF_OE && O_HOLD_ACK_OUT)
    else $error("bus not floated in hold");
  suspend_req_n_enter_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    drain_done_s |=> !O_SUSPEND_ACK_N)
    else $error("suspend not acknowledged after drain");
  busy_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_DRAIN) && busy_s |=> O_SUSPEND_ACK_N)
    else $error("suspend entered while coprocessor busy");
  suspend_req_n_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_RUN) && !suspend_req_n_en && !hold_s && !i_halt_exec |=> st_r == ST_RUN)
    else $error("suspend request not gated");
  ack_float_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !suspend_req_n_en |-> !O_SUSPEND_ACK_OE)
    else $error("suspend ack driven while disabled");
  resume_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_SUSPEND_REQ_N) && !suspend_req_n_req |=> O_SUSPEND_ACK_N && o_core_clk_en)
    else $error("no resume on negated request");
  halt_wake_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_HALT_SUSPEND_REQ_N) && nmi_s |=> st_r == ST_RUN)
    else $error("halt suspend not woken by nmi");
  undouble_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !ckd_bit |=> !doubled_r)
    else $error("still doubled after clear");
  lock_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    $rose(ckd_bit) |-> !doubled_r [*2])
    else $error("doubled before pll lock");
  halt_addr_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    cyc_go && is_halt && !i_shutdown |=> O_WORD_ADDRESS == bus_state_pkg::ADDR_HALT
      && O_HIGH_BYTE_EN_N && !O_LOW_BYTE_EN_N)
    else $error("halt address wrong");
  def_strobe_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    cyc_go |=> !O_ADDR_STROBE_N && O_MEM_IO == $past(i_cyc_type[3]))
    else $error("definition not valid with strobe");

  // Lock stays idle in the strobe cycle and goes active one cycle later
  sequence lock_late_s;
    O_LOCK_N ##1 !O_LOCK_N;
  endsequence

  pipe_lock_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    cyc_go && i_cyc_pipelined && !i_cyc_type[0] |=> lock_late_s)
    else $error("pipelined lock not deferred");
  float_pin_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    float_s |-> !O_ADDR_OE && !O_DEF_OE)
    else $error("outputs driven while float asked");
  lock_lost_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    fchg_s |=> !doubled_r)
    else $error("still doubled after clock change");
  irq_wake_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_HALT_SUSPEND_REQ_N) && irq_s && i_irq_unmasked |=> st_r == ST_RUN)
    else $error("halt suspend not woken by irq");
  masked_stay_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (st_r == ST_HALT_SUSPEND_REQ_N) && !nmi_s && !i_irq_unmasked |=> !O_SUSPEND_ACK_N)
    else $error("halt suspend left without wake");
  self_test_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !rst_seen_r |=> o_self_test_req == $past(busy_s))
    else $error("self test request not taken from busy");

endmodule

// File: bench/pm_partner.sv
/*
  Power-manager model that drives the suspend request pin.
  Assumes it shares the block's clock and reset.
*/
`timescale 1ns/10ps
module pm_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic want,
  input wire logic ack_n,
  input wire logic ack_oe,
  output logic req_n
);
  logic seen_r; // Acknowledge observed for this request
  logic ack_on; // Acknowledge driven and active
  assign ack_on = ack_oe && !ack_n;
  ////////////////////////////////////////////////////////////////////////////
  // Hold the request until acknowledged, then negate it while the core clock is stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      req_n <= 1'b1;
    end else begin
      if (!want) begin
        seen_r <= 1'b0;
      end else if (ack_on) begin
        seen_r <= 1'b1;
      end
      req_n <= !(want && !seen_r && !ack_on);
    end
  end
endmodule

// File: bench/bus_state_ctrl_tb.sv
/*
  Self-checking bench for the bus-state and power-control block.
  Assumes the partner model drives the suspend request pin.
*/
`timescale 1ns/10ps
module bus_state_ctrl_tb;
  localparam int LOCK = 8; // Shortened lock count
  logic clk, rst_n, hold, flt_n, busy_n, nmi, irq, fchg, start, pipe, shut, drained;
  logic unmask, haltx, wr, want, sreq_n, addr_oe, ads_n, mio, dc, wrd, lock_n, def_oe;
  logic bhe_n, ble_n, dbus_oe, smm_oe, hold_ack_out, sack_n, sack_oe, clk_en, dbl, stest, wnmi;
  logic wirq, seen;
  logic [3:0] ctype;
  logic [7:0] wdata, config_ctrl_reg0;
  logic [22:0] caddr, addr;
  int failures = 0;
  int compares = 0;
  int k, j;
  typedef struct {logic [3:0] t; logic sh; logic [22:0] a; logic [22:0] ea;} row_s;
  // Cycle type, shutdown flag, address in, address expected
  row_s rows[10] = '{'{4'h0, 1'b0, 23'h000011, 23'h000011}, '{4'h5, 1'b0, 23'h2AAAAA, 23'h2AAAAA},
    '{4'h7, 1'b0, 23'h555555, 23'h555555}, '{4'h9, 1'b0, 23'h012345, 23'h012345},
    '{4'hB, 1'b0, 23'h7FFF00, 23'h000002}, '{4'hB, 1'b1, 23'h7FFF00, 23'h000000},
    '{4'hC, 1'b0, 23'h000400, 23'h000400}, '{4'hD, 1'b0, 23'h400000, 23'h400000},
    '{4'hE, 1'b0, 23'h0F0F0F, 23'h0F0F0F}, '{4'hF, 1'b0, 23'h70F0F0, 23'h70F0F0}};
  ////////////////////////////////////////////////////////////////////////////
  // Design and partner
  bus_state_ctrl #(.LOCK_CYC(LOCK)) u_bus_state_ctrl (.I_CLK(clk), .I_RESET_N(rst_n),
    .I_HOLD_REQ(hold), .I_SUSPEND_REQ_N(sreq_n), .I_FLOAT_ALL_N(flt_n), .I_CACHE_INV_N(1'b1),
    .I_COPROC_BUSY_N(busy_n), .I_NMI(nmi), .I_MASKABLE_IRQ(irq), .I_CLK_FREQ_CHANGE(fchg),
    .i_cyc_start(start), .i_cyc_type(ctype), .i_cyc_addr(caddr), .i_cyc_pipelined(pipe),
    .i_shutdown(shut), .i_core_drained(drained), .i_irq_unmasked(unmask),
    .i_halt_exec(haltx), .i_config_ctrl_reg0_wr(wr), .i_config_ctrl_reg0_wdata(wdata), .O_WORD_ADDRESS(addr),
    .O_ADDR_OE(addr_oe), .O_ADDR_STROBE_N(ads_n), .O_MEM_IO(mio), .O_DATA_CODE(dc),
    .O_WRITE_READ(wrd), .O_LOCK_N(lock_n), .O_DEF_OE(def_oe), .O_HIGH_BYTE_EN_N(bhe_n),
    .O_LOW_BYTE_EN_N(ble_n), .O_DATA_BUS_OE(dbus_oe), .O_SMM_STROBE_OE(smm_oe),
    .O_HOLD_ACK_OUT(hold_ack_out), .O_SUSPEND_ACK_N(sack_n), .O_SUSPEND_ACK_OE(sack_oe),
    .o_core_clk_en(clk_en), .o_doubled(dbl), .o_self_test_req(stest), .o_wake_nmi(wnmi),
    .o_wake_irq(wirq), .o_config_ctrl_reg0(config_ctrl_reg0));
  pm_partner u_pm_partner (.clk(clk), .rst_n(rst_n), .want(want), .ack_n(sack_n),
    .ack_oe(sack_oe), .req_n(sreq_n));
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_vec(input logic [22:0] got, input logic [22:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Start one bus cycle; returns in the strobe cycle
  task automatic cyc(input logic [3:0] t, input logic sh, input logic p, input logic [22:0] a);
    @(posedge clk);
    start <= 1'b1;
    ctype <= t;
    shut <= sh;
    pipe <= p;
    caddr <= a;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wccr(input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
    chk_vec(23'(config_ctrl_reg0), 23'(v), "config value");
  endtask
  task automatic do_reset(input logic b);
    @(posedge clk);
    rst_n <= 1'b0;
    busy_n <= b;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk_vec(addr, 23'h7FFFFF, "reset address");
    chk_vec(23'({ads_n, dc, lock_n, bhe_n, ble_n, mio, wrd, hold_ack_out}), 23'hE0, "reset pins");
    chk_vec(23'({sack_oe, dbus_oe, smm_oe, dbl, config_ctrl_reg0}), 23'h0, "reset floats");
    @(posedge clk);
    rst_n <= 1'b1;
    step(4);
    chk_bit(stest, !b, "self test");
    @(posedge clk);
    busy_n <= 1'b1;
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog (about 170 cycles expected)
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200us;
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, hold, nmi, irq, fchg, start, pipe, shut, unmask, haltx, wr, want} = '0;
    {flt_n, busy_n, drained} = '1;
    ctype = 4'h0;
    wdata = 8'h00;
    caddr = 23'h0;
    do_reset(1'b1);
    foreach (rows[i]) begin
      cyc(rows[i].t, rows[i].sh, 1'b0, rows[i].a);
      chk_bit(ads_n, 1'b0, "strobe");
      chk_vec(23'({mio, dc, wrd, lock_n}), 23'(rows[i].t), "cycle type");
      chk_vec(addr, rows[i].ea, "word address");
      if (rows[i].t === 4'hB) chk_vec(23'({bhe_n, ble_n}), 23'h2, "halt enables");
      step(1);
      chk_bit(ads_n, 1'b1, "strobe width");
    end
    cyc(4'hC, 1'b0, 1'b1, 23'h0001F0);
    chk_bit(lock_n, 1'b1, "lock deferred");
    step(1);
    chk_bit(lock_n, 1'b0, "pipelined lock");
    $display("test cycles done");
    wccr(8'h40);
    step(LOCK);
    chk_bit(dbl, 1'b0, "early double");
    step(1);
    chk_bit(dbl, 1'b1, "doubled");
    wccr(8'h00);
    step(1);
    chk_bit(dbl, 1'b0, "undoubled");
    wccr(8'h40);
    for (k = 0; k < LOCK + 4 && dbl !== 1'b1; k++) @(negedge clk);
    chk_bit(dbl, 1'b1, "relocked");
    @(posedge clk) fchg <= 1'b1;
    for (k = 0; k < 6 && dbl !== 1'b0; k++) @(negedge clk);
    chk_bit(dbl, 1'b0, "lock lost");
    @(posedge clk) fchg <= 1'b0;
    wccr(8'h00);
    $display("test doubling done");
    @(posedge clk) want <= 1'b1;
    step(6);
    chk_vec(23'({sack_oe, clk_en}), 23'h1, "request ignored");
    @(posedge clk) want <= 1'b0;
    step(4);
    wccr(8'h01);
    chk_bit(sack_oe, 1'b1, "ack enabled");
    @(posedge clk);
    busy_n <= 1'b0;
    drained <= 1'b1;
    want <= 1'b1;
    step(8);
    chk_bit(sack_n, 1'b1, "wait busy");
    @(posedge clk) {busy_n, drained} <= 2'b10;
    step(6);
    chk_bit(sack_n, 1'b1, "wait drain");
    @(posedge clk) drained <= 1'b1;
    for (k = 0; k < 6 && sack_n !== 1'b0; k++) @(negedge clk);
    chk_bit(sack_n, 1'b0, "suspend ack");
    chk_bit(clk_en, 1'b0, "clocks stop");
    for (k = 0; k < 8 && sack_n !== 1'b1; k++) @(negedge clk);
    chk_vec(23'({sack_n, clk_en}), 23'h3, "resume");
    @(posedge clk) want <= 1'b0;
    $display("test suspend done");
    @(posedge clk) hold <= 1'b1;
    for (k = 0; k < 6 && hold_ack_out !== 1'b1; k++) @(negedge clk);
    chk_bit(hold_ack_out, 1'b1, "hold ack");
    chk_vec(23'({addr_oe, def_oe, dbus_oe, clk_en, sack_oe}), 23'h1, "hold floats");
    cyc(4'hD, 1'b0, 1'b0, 23'h000123);
    chk_bit(ads_n, 1'b1, "start ignored");
    @(posedge clk) hold <= 1'b0;
    for (k = 0; k < 6 && hold_ack_out !== 1'b0; k++) @(negedge clk);
    @(posedge clk) flt_n <= 1'b0;
    step(4);
    chk_vec(23'({addr_oe, def_oe}), 23'h0, "float");
    @(posedge clk) flt_n <= 1'b1;
    step(4);
    chk_vec(23'({addr_oe, def_oe}), 23'h3, "float end");
    $display("test hold done");
    for (j = 0; j < 2; j++) begin
      @(posedge clk) haltx <= 1'b1;
      @(posedge clk) haltx <= 1'b0;
      for (k = 0; k < 6 && sack_n !== 1'b0; k++) @(negedge clk);
      chk_bit(sack_n, 1'b0, "halt suspend");
      @(posedge clk) irq <= 1'b1;
      step(6);
      chk_bit(sack_n, 1'b0, "masked stays");
      @(posedge clk);
      nmi <= (j == 0);
      unmask <= (j == 1);
      seen = 1'b0;
      for (k = 0; k < 8 && sack_n !== 1'b1; k++) begin
        @(negedge clk);
        seen = seen | ((j == 0) ? wnmi : wirq);
      end
      chk_bit(seen, 1'b1, "wake pulse");
      chk_bit(sack_n, 1'b1, "wake exit");
      @(posedge clk) {nmi, irq, unmask} <= 3'b000;
    end
    $display("test halt done");
    do_reset(1'b0);
    complete_run();
  end
endmodule
